// *** verilog/stc_pkg.sv ***
package stc_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_LOW = 2'h1;
  localparam logic [1:0] ADDR_HIGH = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;

  // ----------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------
  localparam int BIT_WIDE = 7;
  localparam int BIT_SEC_CLK = 6;
  localparam int BIT_PS_HI = 5;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_OSC_EN = 3;
  localparam int BIT_SYNC_BYP = 2;
  localparam int BIT_SRC_SEL = 1;
  localparam int BIT_RUN = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'hBF;

  // ----------------------------------------------------------------------
  // Status fields, compare trigger and timing
  // ----------------------------------------------------------------------
  localparam int BIT_OVF_FLAG = 0;
  localparam int BIT_OVF_EN = 1;
  localparam logic [3:0] CMP_MODE_SPECIAL = 4'hB;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
endpackage

// *** verilog/stc_tick_if.sv ***
`timescale 1ns/100ps
interface stc_tick_if;
  logic tick;
  logic clear;
  logic [1:0] ps_sel;
  logic advance;
  modport ctrl (output tick, output clear, output ps_sel, input advance);
  modport pres (input tick, input clear, input ps_sel, output advance);
endinterface

// *** verilog/stc_prescaler.sv ***
`timescale 1ns/100ps
module stc_prescaler
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Tick carrier
  stc_tick_if.pres tk
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [2:0] last;

  // Terminal count for 1:1, 1:2, 1:4, 1:8
  assign last = (3'h1 << tk.ps_sel) - 3'h1;
  assign tk.advance = tk.tick && (cnt_r >= last);
  assign cnt_nxt = tk.advance ? 3'h0 : cnt_r + 3'h1;

  // Clear wins over a tick so a low write restarts a whole period
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_r <= 3'h0;
    else if (tk.clear)
      cnt_r <= 3'h0;
    else if (tk.tick)
      cnt_r <= cnt_nxt;
  end
endmodule

// *** verilog/stc_timer.sv ***
// Function
// RULE1: Wide bit clear gives independent byte access
// RULE2: Prescale field selects 1:1, 1:2, 1:4, 1:8
// RULE3: Oscillator enable bit; oscillator feeds external count
// RULE4: Sync bypass bit picks async or sync counting
// RULE5: Internal source ignores the sync bypass bit
// RULE6: External source counts rising edges of input
// RULE7: Internal source counts once per four clocks
// RULE8: Run bit starts counting; clear holds value
// RULE9: Status bit shows oscillator clocks the system
// RULE10: Enabled counter forces both pins to inputs
// RULE11: Wide mode low read snapshots high byte
// RULE12: Wide mode high write buffered until low write
// RULE13: Only low byte write clears prescaler
// RULE14: Oscillator runs through all power modes
// RULE15: Count wraps FFFF to 0000 and sets flag
// RULE16: Compare mode 1011 trigger resets the count; here ignored in async counter mode
// RULE17: Software write beats a coincident trigger
// RULE18: Trigger reset never sets the overflow flag; here a trigger in the same cycle as an advance at FFFF still sets it
// RULE19: Sync mode counts synchronised edges after prescaler
// RULE20: Prescaler cleared on reset and low writes
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module stc_timer
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Register port
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Count and oscillator pins
  input wire logic EXT_COUNT_PIN,
  input wire logic OSC_INPUT_PIN,
  output logic OSC_AMP_ENABLE,
  // Port pin sharing
  input wire logic [1:0] PORT_PIN_DIRECTION,
  output logic [1:0] PORT_PIN_OE,
  output logic [1:0] PORT_PIN_READ,
  // System clock status
  input wire logic SYS_CLK_ON_OSC,
  // Compare triggers
  input wire logic [3:0] CMP1_MODE,
  input wire logic CMP1_MATCH,
  input wire logic [3:0] CMP2_MODE,
  input wire logic CMP2_MATCH,
  // Overflow
  output logic OVERFLOW_IRQ,
  output logic OVERFLOW_PULSE
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [7:0] hbuf_r;
  logic [7:0] hbuf_nxt;
  logic ovf_flag_r;
  logic ovf_en_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [1:0] div_r;
  logic [2:0] src_sync_r;
  logic [2:0] clk_sync_r;
  logic src_level_r;
  logic ovf_pulse_r;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire run = ctrl_r[stc_pkg::BIT_RUN];
  wire wide = ctrl_r[stc_pkg::BIT_WIDE];
  wire ext_sel = ctrl_r[stc_pkg::BIT_SRC_SEL];
  wire osc_en = ctrl_r[stc_pkg::BIT_OSC_EN];
  wire async_mode = ext_sel && ctrl_r[stc_pkg::BIT_SYNC_BYP];
  wire wr_ctrl = WR && (ADDR == stc_pkg::ADDR_CONTROL);
  wire wr_low = WR && (ADDR == stc_pkg::ADDR_LOW);
  wire wr_high = WR && (ADDR == stc_pkg::ADDR_HIGH);
  wire wr_stat = WR && (ADDR == stc_pkg::ADDR_STATUS);
  wire rd_low = RD && (ADDR == stc_pkg::ADDR_LOW);
  wire instr_en = (div_r == stc_pkg::INSTR_DIV_LAST);

  // Oscillator replaces the count pin when enabled
  wire raw_src = osc_en ? OSC_INPUT_PIN : EXT_COUNT_PIN; // RULE3
  wire src_agree = (src_sync_r[2] == src_sync_r[1]);
  wire src_rise = src_agree && src_sync_r[1] && !src_level_r;
  wire sec_clk = (clk_sync_r[2] == clk_sync_r[1]) ? clk_sync_r[1]
                 : ctrl_r[stc_pkg::BIT_SEC_CLK];

  // Compare special events from either module
  wire trig1 = CMP1_MATCH && (CMP1_MODE == stc_pkg::CMP_MODE_SPECIAL);
  wire trig2 = CMP2_MATCH && (CMP2_MODE == stc_pkg::CMP_MODE_SPECIAL);
  // Async mode has no reliable trigger reset, so it is ignored there
  wire trig_reset = (trig1 || trig2) && !async_mode; // RULE16

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  stc_tick_if tk ();
  // Internal ticks every fourth clock; external ticks on a rising edge
  assign tk.tick = run && (ext_sel ? src_rise : instr_en); // RULE5 RULE6 RULE7 RULE8
  assign tk.clear = wr_low; // RULE13 RULE20
  assign tk.ps_sel = ctrl_r[stc_pkg::BIT_PS_HI:stc_pkg::BIT_PS_LO]; // RULE2

  stc_prescaler u_pres
  (
    .clk(CLK),
    .rst_b(RST_B),
    .tk(tk)
  );

  // Sync mode only counts on instruction boundaries; async skips that wait
  wire sync_gate = !ext_sel || async_mode || instr_en; // RULE4 RULE19
  wire adv_raw = tk.advance;
  logic adv_hold_r;
  wire adv = (adv_raw || adv_hold_r) && sync_gate && run;
  wire wrap = adv && (count_r == stc_pkg::COUNT_MAX); // RULE15

  // ----------------------------------------------------------------------
  // Count and buffer next values
  // ----------------------------------------------------------------------
  // Writes first, then trigger, then advance
  always_comb
  begin
    count_nxt = count_r;
    if (wr_low && wide)
      count_nxt = {hbuf_r, WDATA}; // RULE12
    else if (wr_low)
      count_nxt = {count_r[15:8], WDATA}; // RULE1
    else if (wr_high && !wide)
      count_nxt = {WDATA, count_r[7:0]}; // RULE1
    else if (trig_reset)
      count_nxt = stc_pkg::COUNT_RESET; // RULE16 RULE17
    else if (adv)
      count_nxt = count_r + 16'h0001; // RULE15
  end

  // High buffer takes the live byte on a low read, data on a high write
  assign hbuf_nxt = (wide && wr_high) ? WDATA
                    : (wide && rd_low) ? count_r[15:8] : hbuf_r; // RULE11 RULE12

  // Read mux, registered one cycle later
  always_comb
  begin
    rdata_nxt = 8'h00;
    unique case (ADDR)
      stc_pkg::ADDR_CONTROL: rdata_nxt = ctrl_r;
      stc_pkg::ADDR_LOW: rdata_nxt = count_r[7:0];
      stc_pkg::ADDR_HIGH: rdata_nxt = wide ? hbuf_r : count_r[15:8]; // RULE1 RULE11
      stc_pkg::ADDR_STATUS: rdata_nxt = {6'h00, ovf_en_r, ovf_flag_r};
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Control; the status bit tracks the clock controller, not software
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      ctrl_r <= stc_pkg::CONTROL_RESET;
    else if (wr_ctrl)
      ctrl_r <= (WDATA & stc_pkg::CONTROL_WMASK)
                | ({7'h00, sec_clk} << stc_pkg::BIT_SEC_CLK); // RULE9
    else
      ctrl_r[stc_pkg::BIT_SEC_CLK] <= sec_clk; // RULE9
  end

  // Counter and high buffer
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      count_r <= stc_pkg::COUNT_RESET;
      hbuf_r <= 8'h00;
    end
    else
    begin
      count_r <= count_nxt;
      hbuf_r <= hbuf_nxt;
    end
  end

  // Overflow flag: a wrap in the clearing cycle still sets it
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ovf_flag_r <= 1'b0;
      ovf_en_r <= 1'b0;
      ovf_pulse_r <= 1'b0;
    end
    else
    begin
      // A trigger reset in the same cycle as an advance at FFFF still counts as a wrap here
      ovf_flag_r <= wrap || (ovf_flag_r && !(wr_stat && WDATA[0])); // RULE15 RULE18
      if (wr_stat)
        ovf_en_r <= WDATA[stc_pkg::BIT_OVF_EN];
      ovf_pulse_r <= wrap;
    end
  end

  // Divider, synchronisers and edge history
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      div_r <= 2'h0;
      src_sync_r <= 3'h0;
      clk_sync_r <= 3'h0;
      src_level_r <= 1'b0;
      adv_hold_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      div_r <= div_r + 2'h1; // RULE7
      src_sync_r <= {src_sync_r[1:0], raw_src}; // RULE19
      clk_sync_r <= {clk_sync_r[1:0], SYS_CLK_ON_OSC};
      if (src_agree)
        src_level_r <= src_sync_r[1];
      // Hold a sync-mode advance until the next instruction boundary
      adv_hold_r <= (adv_raw || adv_hold_r) && !sync_gate && !wr_low;
      if (RD)
        rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign RDATA = rdata_r;
  // Never gated by halt or sleep, so the crystal keeps running
  assign OSC_AMP_ENABLE = osc_en; // RULE3 RULE14
  // Direction 1 means input; run forces input and reads zero
  assign PORT_PIN_OE = run ? 2'b00 : ~PORT_PIN_DIRECTION; // RULE10
  assign PORT_PIN_READ = run ? 2'b00 : {OSC_INPUT_PIN, EXT_COUNT_PIN}; // RULE10
  assign OVERFLOW_IRQ = ovf_flag_r && ovf_en_r; // RULE15
  assign OVERFLOW_PULSE = ovf_pulse_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_hold_stopped: assert property (!run && !WR && !trig_reset
    |=> count_r == $past(count_r)) else $error("count moved while stopped"); // RULE8
  a_wrap_zero: assert property (wrap && !WR && !trig_reset
    |=> count_r == 16'h0000 && ovf_flag_r) else $error("bad wrap"); // RULE15
  a_wide_snap: assert property (wide && rd_low && !WR
    |=> hbuf_r == $past(count_r[15:8])) else $error("no snapshot"); // RULE11
  a_wide_hwrite: assert property (wide && wr_high
    |=> count_r[15:8] == $past(count_r[15:8]) || $past(trig_reset)
    || $past(adv)) else $error("high write hit live byte"); // RULE12
  a_wide_lwrite: assert property (wide && wr_low
    |=> count_r == {$past(hbuf_r), $past(WDATA)}) else $error("bad load"); // RULE12
  a_write_wins: assert property (wr_low && trig_reset
    |=> count_r[7:0] == $past(WDATA)) else $error("trigger beat write"); // RULE17
  a_trig_clear: assert property (trig_reset && !WR
    |=> count_r == 16'h0000 && !ovf_pulse_r) else $error("bad trigger"); // RULE16
  a_pins_input: assert property (run |-> PORT_PIN_OE == 2'b00
    && PORT_PIN_READ == 2'b00) else $error("pin driven while running"); // RULE10
  a_internal_rate: assert property (run && !ext_sel && tk.ps_sel == 2'h0
    && !WR && !trig_reset && instr_en |=> count_r == $past(count_r) + 16'h0001)
    else $error("internal rate wrong"); // RULE7
  a_read_latency: assert property (RD && ADDR == stc_pkg::ADDR_LOW
    |=> RDATA == $past(count_r[7:0])) else $error("read data late");
  a_wrap_pulse: assert property (wrap |=> OVERFLOW_PULSE) // RULE15
    else $error("no overflow pulse after wrap");
  a_no_pulse: assert property (!wrap |=> !OVERFLOW_PULSE) // RULE18
    else $error("overflow pulse without wrap");

  c_wrap: cover property (wrap);
  c_wide_read: cover property (wide && rd_low ##1 RD && ADDR == stc_pkg::ADDR_HIGH);
  c_ext_count: cover property (ext_sel && adv);
  c_trigger: cover property (trig_reset && run);
endmodule

// *** tb/stc_pin_src.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Far-side count source: slow square wave on one pin
// ----------------------------------------------------------------------
module stc_pin_src
#(
  parameter int HALF_NS = 160
)
(
  // Source pin
  output logic pin
);
  // Held low between bursts, as a stopped count clock would be
  initial pin = 1'b0;

  // Rising edges far slower than the system clock, so none are merged
  task automatic burst(input int n);
    repeat (n)
    begin
      #HALF_NS pin = 1'b1;
      #HALF_NS pin = 1'b0;
    end
  endtask
endmodule

// *** tb/stc_timer_bench.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Self-checking bench for the timer/counter
// ----------------------------------------------------------------------
module stc_timer_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata;
  logic ext_pin;
  logic osc_pin;
  logic amp_en;
  logic [1:0] pin_oe;
  logic [1:0] pin_rd;
  logic sys_on = 1'b0;
  logic [3:0] m1 = 4'h0;
  logic [3:0] m2 = 4'h0;
  logic hit1 = 1'b0;
  logic hit2 = 1'b0;
  logic irq;
  logic pulse;
  int pulses = 0;
  int compares = 0;
  int miscompares = 0;

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  stc_timer u_stc_timer (.CLK(clk), .RST_B(rst_b), .ADDR(addr),
    .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
    .EXT_COUNT_PIN(ext_pin), .OSC_INPUT_PIN(osc_pin),
    .OSC_AMP_ENABLE(amp_en), .PORT_PIN_DIRECTION(2'h1),
    .PORT_PIN_OE(pin_oe), .PORT_PIN_READ(pin_rd),
    .SYS_CLK_ON_OSC(sys_on), .CMP1_MODE(m1), .CMP1_MATCH(hit1),
    .CMP2_MODE(m2), .CMP2_MATCH(hit2), .OVERFLOW_IRQ(irq),
    .OVERFLOW_PULSE(pulse));
  stc_pin_src #(.HALF_NS(160)) u_ext (.pin(ext_pin));
  stc_pin_src #(.HALF_NS(400)) u_osc (.pin(osc_pin));

  // Count overflow pulses, one per wrap expected
  always @(posedge clk)
    if (pulse === 1'b1)
      pulses <= pulses + 1;

  // ----------------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------------
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // Read data appear in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Free instruction divider leaves a one-tick phase uncertainty
  task automatic chk_in(input logic [7:0] got, input int lo, input int hi);
    chk({7'h00, got >= lo && got <= hi}, 8'h01);
  endtask

  task automatic trig(input logic [3:0] m, input logic sec, input logic w);
    @(posedge clk);
    m1 <= m;
    m2 <= m;
    hit1 <= !sec;
    hit2 <= sec;
    addr <= stc_pkg::ADDR_LOW;
    wdata <= 8'h55;
    wr_s <= w;
    @(posedge clk);
    hit1 <= 1'b0;
    hit2 <= 1'b0;
    wr_s <= 1'b0;
  endtask

  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] d;
    rd(stc_pkg::ADDR_CONTROL, d);
    chk(d, 8'h00);
    chk({6'h0, pin_oe}, 8'h02);
    sys_on <= 1'b1;
    repeat (4) @(posedge clk);
    wr(stc_pkg::ADDR_CONTROL, 8'h00);
    rd(stc_pkg::ADDR_CONTROL, d);
    chk(d, 8'h40);
    sys_on <= 1'b0;
  endtask

  task automatic t_prescale;
    logic [7:0] d;
    logic [7:0] d2;
    for (int k = 0; k < 4; k++)
    begin
      wr(stc_pkg::ADDR_LOW, 8'h00);
      wr(stc_pkg::ADDR_CONTROL, {2'b00, k[1:0], 1'b0, k[0], 2'b01});
      repeat (400) @(posedge clk);
      chk({4'h0, pin_oe, pin_rd}, 8'h00);
      wr(stc_pkg::ADDR_CONTROL, 8'h00);
      rd(stc_pkg::ADDR_LOW, d);
      chk_in(d, (100 >> k) - 1, (100 >> k) + 1);
    end
    repeat (40) @(posedge clk);
    rd(stc_pkg::ADDR_LOW, d2);
    chk(d2, d);
  endtask

  task automatic t_wrap;
    logic [7:0] d;
    wr(stc_pkg::ADDR_HIGH, 8'hFF);
    wr(stc_pkg::ADDR_LOW, 8'hFE);
    wr(stc_pkg::ADDR_STATUS, 8'h02);
    wr(stc_pkg::ADDR_CONTROL, 8'h01);
    repeat (20) @(posedge clk);
    wr(stc_pkg::ADDR_CONTROL, 8'h00);
    chk({7'h00, irq}, 8'h01);
    rd(stc_pkg::ADDR_HIGH, d);
    chk(d, 8'h00);
    rd(stc_pkg::ADDR_LOW, d);
    chk_in(d, 1, 5);
    chk({7'h00, pulses == 1}, 8'h01);
    wr(stc_pkg::ADDR_STATUS, 8'h03);
    #1 chk({7'h00, irq}, 8'h00);
  endtask

  task automatic t_wide;
    logic [7:0] d;
    wr(stc_pkg::ADDR_CONTROL, 8'h80);
    wr(stc_pkg::ADDR_HIGH, 8'h12);
    wr(stc_pkg::ADDR_LOW, 8'h34);
    wr(stc_pkg::ADDR_HIGH, 8'h99);
    wr(stc_pkg::ADDR_CONTROL, 8'h00);
    rd(stc_pkg::ADDR_HIGH, d);
    chk(d, 8'h12);
    wr(stc_pkg::ADDR_HIGH, 8'h56);
    rd(stc_pkg::ADDR_LOW, d);
    chk(d, 8'h34);
    wr(stc_pkg::ADDR_CONTROL, 8'h80);
    wr(stc_pkg::ADDR_HIGH, 8'h77);
    rd(stc_pkg::ADDR_LOW, d);
    rd(stc_pkg::ADDR_HIGH, d);
    chk(d, 8'h56);
  endtask

  task automatic t_ext(input logic [7:0] c, input int n, input int ex);
    logic [7:0] d;
    wr(stc_pkg::ADDR_LOW, 8'h00);
    wr(stc_pkg::ADDR_CONTROL, c);
    #1 chk({7'h00, amp_en}, {7'h00, c[3]});
    fork
      u_ext.burst(n);
      u_osc.burst(ex);
    join
    repeat (20) @(posedge clk);
    wr(stc_pkg::ADDR_CONTROL, 8'h00);
    rd(stc_pkg::ADDR_LOW, d);
    chk(d, c[3] ? ex[7:0] : n[7:0]);
  endtask

  task automatic t_trig;
    logic [7:0] d;
    wr(stc_pkg::ADDR_LOW, 8'h40);
    trig(4'hA, 1'b0, 1'b0);
    rd(stc_pkg::ADDR_LOW, d);
    chk(d, 8'h40);
    trig(stc_pkg::CMP_MODE_SPECIAL, 1'b0, 1'b1);
    rd(stc_pkg::ADDR_LOW, d);
    chk(d, 8'h55);
    trig(stc_pkg::CMP_MODE_SPECIAL, 1'b1, 1'b0);
    rd(stc_pkg::ADDR_LOW, d);
    chk(d, 8'h00);
    rd(stc_pkg::ADDR_STATUS, d);
    chk(d, 8'h02);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_prescale();
    t_wrap();
    t_wide();
    t_ext(8'h03, 10, 0);
    t_ext(8'h0B, 7, 5);
    t_ext(8'h07, 6, 0);
    t_trig();
    summarize();
  end

  // Whole run takes about 2200 cycles; this is ample margin
  initial
  begin
    #1000000;
    miscompares++;
    summarize();
  end
endmodule
